// >>> include/ebpc_params.svh
// timing counts, reset values and field widths of the external bus pin control
`ifndef EBPC_PARAMS_SVH
`define EBPC_PARAMS_SVH

`define EBPC_ADDR_W       20
`define EBPC_ADDR_LO_W    16
`define EBPC_DATA_W       16
`define EBPC_SYNC_W       3
`define EBPC_SYNC_RST     3'h7
`define EBPC_SYNC_EMU     2
`define EBPC_SYNC_HOLD    1
`define EBPC_SYNC_RSTPIN  0
`define EBPC_ADDR_CYC     2'h1
`define EBPC_XFER_CYC     2'h2
`define EBPC_HOLDER_RST   1'b0
`define EBPC_ADDR_RST     20'h00000
`define EBPC_DATA_RST     16'h0000

`endif

// >>> include/ebpc_pkg.sv
// types shared by the external bus pin control
`default_nettype none
`include "ebpc_params.svh"

package ebpc_pkg;

    typedef enum logic [1:0]
    {
        EBPC_SPACE_PROG = 2'h0,
        EBPC_SPACE_DATA = 2'h1,
        EBPC_SPACE_IO   = 2'h2,
        EBPC_SPACE_VECT = 2'h3
    } ebpc_space_type;

    typedef enum logic [3:0]
    {
        EBPC_ST_IDLE = 4'h1,
        EBPC_ST_ADDR = 4'h2,
        EBPC_ST_XFER = 4'h4,
        EBPC_ST_HELD = 4'h8
    } ebpc_state_type;

    typedef struct packed
    {
        ebpc_space_type              space;
        logic                        write;
        logic [`EBPC_ADDR_W-1:0]     addr;
        logic [`EBPC_DATA_W-1:0]     wdata;
    } ebpc_req_type;

    typedef struct packed
    {
        logic [`EBPC_ADDR_W-1:0]     addr;
        logic                        addr_lo_oe;
        logic                        addr_hi_oe;
        logic [`EBPC_DATA_W-1:0]     data_out;
        logic                        data_oe;
        logic [`EBPC_DATA_W-1:0]     keep_val;
        logic                        keep_en;
        logic                        interrupt_ack_n;
        logic                        interrupt_ack_oe;
        logic                        hold_ack_n;
    } ebpc_pins_type;

endpackage

`default_nettype wire

// >>> logic/ebpc_pin_sync.sv
// three-flop pin synchroniser; a bit changes once the second and third flops agree
`default_nettype none

module ebpc_pin_sync
#(
    parameter int                W       = 1,
    parameter logic [W-1:0]      RST_VAL = '0
)
(
    input  wire logic            clk_sys,
    input  wire logic            rstn,
    input  wire logic [W-1:0]    pin_in,
    output var  logic [W-1:0]    pin_out
);

    logic [W-1:0]    s1_r;
    logic [W-1:0]    s2_r;
    logic [W-1:0]    s3_r;
    logic [W-1:0]    agree;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            s1_r <= RST_VAL;
            s2_r <= RST_VAL;
            s3_r <= RST_VAL;
        end
        else
        begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    assign agree = ~(s2_r ^ s3_r);

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            pin_out <= RST_VAL;
        else
            pin_out <= (s3_r & agree) | (pin_out & ~agree);
    end

endmodule

`default_nettype wire

// >>> logic/ebpc_bus_pins.sv
// external parallel bus pin control: address, data, holders, interrupt acknowledge, hold
//
// What this block does
// R01: low sixteen address lines address program, data and I/O spaces alike.
// R02: upper four address lines are driven only for program space accesses.
// R03: all address lines float in hold mode or while emulator-off is low.
// R04: one shared sixteen-bit bidirectional data bus moves words for every space.
// R05: data drivers float unless writing, and while reset pin or hold asserted.
// R06: data bus floats whenever emulator-off is low, whatever transfer runs.
// R07: enabled holders keep each undriven data pin at its last level.
// R08: holders disabled at reset; software toggles them via the holder-enable bit.
// R09: interrupt acknowledge asserts during vector fetch; vector sits on low address.
// R10: interrupt acknowledge output floats whenever emulator-off is low.
// R11: external master requests hold; once acknowledged device releases its lines.
`default_nettype none
`include "ebpc_params.svh"

module ebpc_bus_pins
(
    input  wire logic                         clk_sys,
    input  wire logic                         rstn,
    input  wire logic                         emulator_off_n,
    input  wire logic                         hold_req_n,
    input  wire logic                         reset_pin_n,
    input  wire logic [`EBPC_DATA_W-1:0]      data_in,
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire ebpc_pkg::ebpc_req_type       req,
    input  wire logic                         interrupt_ack_n_valid,
    output logic                              interrupt_ack_n_ready,
    input  wire logic [`EBPC_ADDR_LO_W-1:0]   interrupt_ack_n_vector,
    output logic                              rsp_valid,
    output logic [`EBPC_DATA_W-1:0]           rsp_rdata,
    input  wire logic                         bank_switch_control_wr,
    input  wire logic                         bank_switch_control_bh,
    output logic                              bus_holder_enable,
    output ebpc_pkg::ebpc_pins_type           pins
);

    import ebpc_pkg::*;

    logic [`EBPC_SYNC_W-1:0]    sync_out;
    logic                       emu_on;
    logic                       hold_s;
    logic                       rst_pin_s;
    logic [`EBPC_DATA_W-1:0]    data_s;

    ebpc_state_type             state_r;
    ebpc_state_type             state_nxt;
    logic [1:0]                 cnt_r;
    logic [1:0]                 cnt_nxt;
    ebpc_space_type             space_r;
    logic                       write_r;
    logic [`EBPC_ADDR_W-1:0]    addr_r;
    logic [`EBPC_DATA_W-1:0]    wdata_r;
    logic [`EBPC_DATA_W-1:0]    rdata_r;
    logic                       rsp_valid_r;
    logic                       hold_ack_n_r;
    logic                       holder_en_r;
    logic [`EBPC_DATA_W-1:0]    keep_r;
    logic                       idle_free;
    logic                       take_interrupt_ack_n;
    logic                       take_req;
    logic                       xfer_last;
    logic                       driving_data;
    logic                       interrupt_ack_n_n_r;

    function automatic logic space_uses_top(input ebpc_space_type sp);
        space_uses_top = (sp == EBPC_SPACE_PROG);
    endfunction

    function automatic logic addr_may_drive(input ebpc_state_type st, input logic emu);
        addr_may_drive = emu && (st != EBPC_ST_HELD);
    endfunction

    // control pins from outside come through three synchroniser flops and an output flop
    ebpc_pin_sync
    #(
        .W       (`EBPC_SYNC_W),
        .RST_VAL (`EBPC_SYNC_RST)
    )
    u_pin_sync
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .pin_in  ({emulator_off_n, hold_req_n, reset_pin_n}),
        .pin_out (sync_out)
    );

    assign emu_on    = sync_out[`EBPC_SYNC_EMU];
    assign hold_s    = ~sync_out[`EBPC_SYNC_HOLD];
    assign rst_pin_s = ~sync_out[`EBPC_SYNC_RSTPIN];
    // data pins answer our own registered address, so they share this clock;
    // a synchroniser here would sample the level from before the address
    assign data_s    = data_in;

    // requests only accepted when idle and the bus is ours
    assign idle_free  = (state_r == EBPC_ST_IDLE) && !hold_s && !rst_pin_s;
    assign interrupt_ack_n_ready = idle_free;
    assign req_ready  = idle_free && !interrupt_ack_n_valid;
    assign take_interrupt_ack_n  = idle_free && interrupt_ack_n_valid;
    assign take_req   = req_ready && req_valid;
    assign xfer_last  = (state_r == EBPC_ST_XFER) && (cnt_r == `EBPC_XFER_CYC - 2'h1);

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        case (state_r)
            EBPC_ST_IDLE:
            begin
                cnt_nxt = 2'h0;
                // R11 grant hold
                if (hold_s && !rst_pin_s)
                    state_nxt = EBPC_ST_HELD;
                else if (take_interrupt_ack_n || take_req)
                    state_nxt = EBPC_ST_ADDR;
            end
            EBPC_ST_ADDR:
            begin
                if (cnt_r == `EBPC_ADDR_CYC - 2'h1)
                begin
                    state_nxt = EBPC_ST_XFER;
                    cnt_nxt   = 2'h0;
                end
                else
                    cnt_nxt = cnt_r + 2'h1;
            end
            EBPC_ST_XFER:
            begin
                if (xfer_last)
                begin
                    state_nxt = EBPC_ST_IDLE;
                    cnt_nxt   = 2'h0;
                end
                else
                    cnt_nxt = cnt_r + 2'h1;
            end
            EBPC_ST_HELD:
            begin
                cnt_nxt = 2'h0;
                if (!hold_s)
                    state_nxt = EBPC_ST_IDLE;
            end
            default:
            begin
                state_nxt = EBPC_ST_IDLE;
                cnt_nxt   = 2'h0;
            end
        endcase
        // reset pin aborts any access in flight
        if (rst_pin_s)
        begin
            state_nxt = EBPC_ST_IDLE;
            cnt_nxt   = 2'h0;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r <= EBPC_ST_IDLE;
            cnt_r   <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // latch the access; upper address only kept for program space
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            space_r <= EBPC_SPACE_DATA;
            write_r <= 1'b0;
            addr_r  <= `EBPC_ADDR_RST;
            wdata_r <= `EBPC_DATA_RST;
        end
        else if (take_interrupt_ack_n)
        begin
            // R09 vector on low address
            space_r <= EBPC_SPACE_VECT;
            write_r <= 1'b0;
            addr_r  <= {4'h0, interrupt_ack_n_vector};
        end
        else if (take_req)
        begin
            space_r <= req.space;
            write_r <= req.write;
            // R01 low sixteen for all spaces
            addr_r[`EBPC_ADDR_LO_W-1:0] <= req.addr[`EBPC_ADDR_LO_W-1:0];
            // R02 top bits for program only
            if (space_uses_top(req.space))
                addr_r[`EBPC_ADDR_W-1:`EBPC_ADDR_LO_W] <= req.addr[`EBPC_ADDR_W-1:`EBPC_ADDR_LO_W];
            wdata_r <= req.wdata;
        end
    end

    // R04 read words come back over the shared data bus
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            rdata_r     <= `EBPC_DATA_RST;
            rsp_valid_r <= 1'b0;
        end
        else
        begin
            rsp_valid_r <= xfer_last && !rst_pin_s;
            if (xfer_last && !write_r)
                rdata_r <= data_s;
        end
    end

    // R11 acknowledge only once idle
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            hold_ack_n_r <= 1'b1;
        else
            hold_ack_n_r <= !(state_nxt == EBPC_ST_HELD);
    end

    // R08 holders off at reset, software sets them later
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            holder_en_r <= `EBPC_HOLDER_RST;
        else if (rst_pin_s)
            holder_en_r <= `EBPC_HOLDER_RST;
        else if (bank_switch_control_wr)
            holder_en_r <= bank_switch_control_bh;
    end

    // R09 acknowledge from a flop
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            interrupt_ack_n_n_r <= 1'b1;
        else if (take_interrupt_ack_n)
            interrupt_ack_n_n_r <= 1'b0;
        else if (state_nxt == EBPC_ST_IDLE)
            interrupt_ack_n_n_r <= 1'b1;
    end

    // R05 R06 drive data only while writing, own bus, emulator on
    // hold floats the data at once, even mid-write; the access still runs out
    assign driving_data = (state_r == EBPC_ST_XFER) && write_r && emu_on && !hold_s && !rst_pin_s;

    // R07 keep last level seen on the pins
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            keep_r <= `EBPC_DATA_RST;
        else if (driving_data)
            keep_r <= wdata_r;
        else
            keep_r <= data_s;
    end

    assign rsp_valid         = rsp_valid_r;
    assign rsp_rdata         = rdata_r;
    assign bus_holder_enable = holder_en_r;

    always_comb
    begin
        pins.addr       = addr_r;
        // R03 address floats in hold or emulator off
        pins.addr_lo_oe = addr_may_drive(state_r, emu_on);
        pins.addr_hi_oe = addr_may_drive(state_r, emu_on) && space_uses_top(space_r);
        pins.data_out   = wdata_r;
        pins.data_oe    = driving_data;
        pins.keep_val   = keep_r;
        pins.keep_en    = holder_en_r && !driving_data;
        // R09 acknowledge during vector fetch
        pins.interrupt_ack_n  = interrupt_ack_n_n_r;
        // R10 acknowledge floats with emulator off
        pins.interrupt_ack_oe = emu_on;
        pins.hold_ack_n       = hold_ack_n_r;
    end

endmodule

`default_nettype wire

// >>> tb/ebpc_bus_pins_checker.sv
// concurrent checks on the external bus pin control ports
`default_nettype none

module ebpc_bus_pins_checker
(
    input wire logic                    clk_sys,
    input wire logic                    rstn,
    input wire logic                    emulator_off_n,
    input wire logic                    reset_pin_n,
    input wire logic                    req_valid,
    input wire logic                    req_ready,
    input wire ebpc_pkg::ebpc_req_type  req,
    input wire logic                    interrupt_ack_n_valid,
    input wire logic                    interrupt_ack_n_ready,
    input wire logic [15:0]             interrupt_ack_n_vector,
    input wire logic                    rsp_valid,
    input wire logic                    bus_holder_enable,
    input wire ebpc_pkg::ebpc_pins_type pins
);
    timeunit 1ns;
    timeprecision 100ps;
    import ebpc_pkg::*;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    wire take = req_valid && req_ready;
    property p_lo; take |-> ##1 pins.addr[15:0] == $past(req.addr[15:0]); endproperty
    a_lo: assert property (p_lo) else $error("low address wrong");
    property p_hi; take && req.space != EBPC_SPACE_PROG |-> ##1 !pins.addr_hi_oe; endproperty
    a_hi: assert property (p_hi) else $error("upper address driven");
    property p_emu; (!emulator_off_n)[*5] |-> !(pins.addr_lo_oe || pins.addr_hi_oe || pins.data_oe); endproperty
    a_emu: assert property (p_emu) else $error("bus driven while off");
    property p_iof; (!emulator_off_n)[*5] |-> !pins.interrupt_ack_oe; endproperty
    a_iof: assert property (p_iof) else $error("ack driven while off");
    property p_rsp; take |-> ##[4:5] rsp_valid; endproperty
    a_rsp: assert property (p_rsp) else $error("no response");
    property p_wd; take && req.write |-> ##2 pins.data_out == $past(req.wdata, 2); endproperty
    a_wd: assert property (p_wd) else $error("write data wrong");
    property p_vec; interrupt_ack_n_valid && interrupt_ack_n_ready |-> ##2 !pins.interrupt_ack_n && pins.addr[15:0] == $past(interrupt_ack_n_vector, 2);
    endproperty
    a_vec: assert property (p_vec) else $error("vector fetch wrong");
    property p_hold; !pins.hold_ack_n |-> !(pins.addr_lo_oe || pins.addr_hi_oe || pins.data_oe); endproperty
    a_hold: assert property (p_hold) else $error("bus driven in hold");
    property p_rst; (!reset_pin_n)[*6] |-> !pins.data_oe && !bus_holder_enable && !req_ready; endproperty
    a_rst: assert property (p_rst) else $error("reset pin ignored");
    property p_keep; pins.keep_en |-> bus_holder_enable && !pins.data_oe; endproperty
    a_keep: assert property (p_keep) else $error("holder on wrongly");
    c_rsp: cover property (take ##[4:5] rsp_valid);
    c_hold: cover property (!pins.hold_ack_n);
    c_vec: cover property (!pins.interrupt_ack_n);
endmodule

`default_nettype wire

// >>> tb/ebpc_mem_model.sv
// external memory and I/O seen on the shared data pins
`default_nettype none

module ebpc_mem_model
(
    input wire logic                    clk_sys,
    input wire logic                    drv,
    input wire ebpc_pkg::ebpc_pins_type pins,
    output var logic [15:0]             data_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [0:65535];
    logic [15:0] last_r;
    always_ff @(posedge clk_sys)
    begin
        if (pins.data_oe)
            mem[pins.addr[15:0]] <= pins.data_out;
        last_r <= data_in;
    end
    // released wire toggles unless a holder keeps it
    always_comb
    begin
        if (pins.data_oe)
            data_in = pins.data_out;
        else if (drv)
            data_in = mem[pins.addr[15:0]];
        else if (pins.keep_en)
            data_in = pins.keep_val;
        else
            data_in = ~last_r;
    end
endmodule

`default_nettype wire

// >>> tb/ebpc_bus_pins_test.sv
// self-checking bench of the external bus pin control
`default_nettype none

module ebpc_bus_pins_test;
    timeunit 1ns;
    timeprecision 100ps;
    import ebpc_pkg::*;
    logic clk_sys = 0, rstn = 0, emu_n = 1, hold_n = 1, rst_pin_n = 1, drv = 0;
    logic req_valid = 0, interrupt_ack_n_valid = 0, bs_wr = 0, bs_bh = 0;
    logic req_ready, interrupt_ack_n_ready, rsp_valid, holder;
    logic [15:0] data_in, rsp_rdata, vec = 16'h0000, rd;
    ebpc_req_type req = '0;
    ebpc_pins_type pins;
    int errors = 0, checked = 0, seed = 56677, n;
    logic [15:0] exp_q [$];
    always #12.5 clk_sys = ~clk_sys;
    ebpc_bus_pins DUT (.clk_sys(clk_sys), .rstn(rstn), .emulator_off_n(emu_n), .hold_req_n(hold_n),
        .reset_pin_n(rst_pin_n), .data_in(data_in), .req_valid(req_valid), .req_ready(req_ready), .req(req),
        .interrupt_ack_n_valid(interrupt_ack_n_valid), .interrupt_ack_n_ready(interrupt_ack_n_ready), .interrupt_ack_n_vector(vec), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .bank_switch_control_wr(bs_wr), .bank_switch_control_bh(bs_bh),
        .bus_holder_enable(holder), .pins(pins));
    ebpc_mem_model u_mem (.clk_sys(clk_sys), .drv(drv), .pins(pins), .data_in(data_in));
    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #2;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // 0 request ready, 1 vector ready, 2 response, 3 hold granted
    function automatic logic seen_high(input int sel);
        case (sel)
            0: seen_high = req_ready;
            1: seen_high = interrupt_ack_n_ready;
            2: seen_high = rsp_valid;
            default: seen_high = !pins.hold_ack_n;
        endcase
    endfunction
    task automatic wait_for(input int sel);
        for (n = 0; n < 40 && seen_high(sel) !== 1'b1; n++)
            tick(1);
        if (seen_high(sel) !== 1'b1)
        begin
            errors++;
            $display("[ERR] %0t wait %0d ran out", $time, sel);
            conclude();
        end
    endtask
    // space 3 means a vector fetch
    task automatic access(input logic [1:0] sp, input logic wr, input logic [19:0] a, input logic [15:0] d);
        if (sp == 2'h3)
            wait_for(1);
        else
            wait_for(0);
        req = '{space: ebpc_space_type'(sp), write: wr, addr: a, wdata: d};
        vec = a[15:0];
        if (sp == 2'h3) interrupt_ack_n_valid = 1; else req_valid = 1;
        tick(1);
        req_valid = 0;
        interrupt_ack_n_valid = 0;
        chk(pins.addr[15:0], a[15:0]);
        if (emu_n) chk(pins.addr_hi_oe, sp == 2'h0);
        if (sp == 2'h0) chk(pins.addr[19:16], a[19:16]);
        tick(1);
        chk(pins.interrupt_ack_n, sp != 2'h3);
        wait_for(2);
        rd = rsp_rdata;
    endtask
    initial
    begin
        tick(12);
        rstn = 1;
        tick(1);
        chk({pins.data_oe, pins.keep_en, holder, pins.interrupt_ack_n, pins.hold_ack_n}, 5'h03);
        for (int i = 0; i < 9; i++)
        begin
            logic [19:0] a;
            a = 20'($random(seed));
            bs_wr = 1;
            bs_bh = i[0];
            tick(1);
            bs_wr = 0;
            exp_q.push_back(16'($random(seed)));
            access(2'(i % 3), 1, a, exp_q[$]);
            drv = !i[0];
            access(2'(i % 3), 0, a, 16'h0000);
            chk(rd, exp_q.pop_front());
            drv = 0;
        end
        access(2'h3, 0, 20'h0FF80, 16'h0000);
        $display("test access done");
        emu_n = 0;
        tick(6);
        access(2'h1, 1, 20'h00123, 16'hA5A5);
        chk({pins.addr_lo_oe, pins.addr_hi_oe, pins.data_oe, pins.interrupt_ack_oe}, 4'h0);
        emu_n = 1;
        hold_n = 0;
        tick(3);
        wait_for(3);
        chk({pins.addr_lo_oe, pins.data_oe, req_ready}, 3'h0);
        hold_n = 1;
        tick(6);
        chk(pins.hold_ack_n, 1);
        bs_wr = 1;
        bs_bh = 1;
        tick(1);
        bs_wr = 0;
        rst_pin_n = 0;
        tick(6);
        chk({holder, pins.data_oe, req_ready}, 3'h0);
        rst_pin_n = 1;
        tick(6);
        $display("test pins done");
        conclude();
    end
endmodule

bind ebpc_bus_pins ebpc_bus_pins_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .emulator_off_n(emulator_off_n),
    .reset_pin_n(reset_pin_n), .req_valid(req_valid), .req_ready(req_ready), .req(req), .interrupt_ack_n_valid(interrupt_ack_n_valid),
    .interrupt_ack_n_ready(interrupt_ack_n_ready), .interrupt_ack_n_vector(interrupt_ack_n_vector), .rsp_valid(rsp_valid),
    .bus_holder_enable(bus_holder_enable), .pins(pins));

`default_nettype wire
